// ### common/nand_host_defines.vh
// Constants for the NAND flash host pin sequencer
`ifndef NAND_HOST_DEFINES_VH
`define NAND_HOST_DEFINES_VH

// ==========================================================
// Request kinds on the user command port
`define KIND_W           3
`define KIND_CMD         3'h0
`define KIND_ADDR        3'h1
`define KIND_ADDR5       3'h2
`define KIND_WDATA       3'h3
`define KIND_RDATA       3'h4
`define KIND_WAIT        3'h5
`define KIND_DESEL       3'h6

// ==========================================================
// Bus shape
`define IO_W_DEF         8
`define ADDR_BYTES       5
`define ADDR_BITS        40

// ==========================================================
// Pin timing, nanoseconds, and derived core_clk cycle counts
`define CLK_PERIOD_NS    25
`define T_SETUP_NS       25
`define T_WE_LOW_NS      25
`define T_HOLD_NS        25
`define T_RE_LOW_NS      75
`define T_RE_HIGH_NS     25
`define T_BUSY_START_NS  100
`define SETUP_CYC        ((`T_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WE_LOW_CYC       ((`T_WE_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOLD_CYC         ((`T_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RE_LOW_CYC       ((`T_RE_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RE_HIGH_CYC      ((`T_RE_HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BUSY_START_CYC   ((`T_BUSY_START_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W            8

`endif

// ### hw/nand_host_seq.v
// Host-side NAND flash command bus sequencer
`timescale 1ns/1ps
`include "nand_host_defines.vh"

module nand_host_seq #(
  parameter IO_W = `IO_W_DEF
) (
  input  wire                   core_clk,
  input  wire                   rst_n,
  input  wire                   clk_en,
  input  wire                   cmd_valid,
  input  wire [`KIND_W-1:0]     cmd_kind,
  input  wire [IO_W-1:0]        cmd_data,
  input  wire [`ADDR_BITS-1:0]  cmd_addr,
  output reg                    cmd_ready,
  output reg                    cmd_done,
  output reg  [IO_W-1:0]        rd_data,
  output reg                    dev_busy,
  input  wire                   write_protect,
  input  wire                   lock_enable,
  output reg                    cle,
  output reg                    ale,
  output reg                    ce_n,
  output reg                    re_n,
  output reg                    we_n,
  output reg                    wp_n,
  output reg                    lock,
  output reg  [IO_W-1:0]        io_out,
  output reg                    io_oe,
  input  wire [IO_W-1:0]        io_in,
  input  wire                   rb_n_in
);

  // ==========================================================
  // States
  localparam [7:0] S_IDLE   = 8'h01;
  localparam [7:0] S_SETUP  = 8'h02;
  localparam [7:0] S_STROBE = 8'h04;
  localparam [7:0] S_HOLD   = 8'h08;
  localparam [7:0] S_RDLOW  = 8'h10;
  localparam [7:0] S_RDHIGH = 8'h20;
  localparam [7:0] S_WAITB  = 8'h40;
  localparam [7:0] S_WAITR  = 8'h80;

  // Cycle counts kept at full width, only compared against
  localparam integer SETUP_N = `SETUP_CYC;
  localparam integer WE_N    = `WE_LOW_CYC;
  localparam integer HOLD_N  = `HOLD_CYC;
  localparam integer RELOW_N = `RE_LOW_CYC;
  localparam integer REHI_N  = `RE_HIGH_CYC;
  localparam integer BSTRT_N = `BUSY_START_CYC;

  // Byte widened onto the bus, upper lines low
  function [IO_W-1:0] widen;
    input [7:0] b;
    begin
      widen = {IO_W{1'b0}};
      widen[7:0] = b;
    end
  endfunction

  reg [7:0]             state_r;
  reg [`KIND_W-1:0]     kind_r;
  reg [`CNT_W-1:0]      cnt_r;
  reg [`ADDR_BITS-1:0]  addr_r;
  reg [2:0]             byte_idx_r;
  reg [IO_W-1:0]        io_meta_r;
  reg [IO_W-1:0]        io_sync_r;
  reg                   rb_meta_r;
  reg                   rb_sync_r;

  // ==========================================================
  // Pin input synchronisers
  always @(posedge core_clk) begin
    if (!rst_n) begin
      io_meta_r <= {IO_W{1'b0}};
      io_sync_r <= {IO_W{1'b0}};
      rb_meta_r <= 1'b1;
      rb_sync_r <= 1'b1;
    end else if (clk_en) begin
      io_meta_r <= io_in;
      io_sync_r <= io_meta_r;
      rb_meta_r <= rb_n_in;
      rb_sync_r <= rb_meta_r;
    end
  end

  // ==========================================================
  // Pin sequencer
  always @(posedge core_clk) begin
    if (!rst_n) begin
      state_r    <= S_IDLE;
      kind_r     <= `KIND_CMD;
      cnt_r      <= {`CNT_W{1'b0}};
      addr_r     <= {`ADDR_BITS{1'b0}};
      byte_idx_r <= 3'h0;
      cmd_ready  <= 1'b0;
      cmd_done   <= 1'b0;
      rd_data    <= {IO_W{1'b0}};
      dev_busy   <= 1'b0;
      cle        <= 1'b0;
      ale        <= 1'b0;
      ce_n       <= 1'b1;
      re_n       <= 1'b1;
      we_n       <= 1'b1;
      wp_n       <= 1'b0;
      lock       <= 1'b0;
      io_out     <= {IO_W{1'b0}};
      io_oe      <= 1'b0;
    end else if (clk_en) begin
      cmd_done <= 1'b0;
      wp_n     <= ~write_protect;
      lock     <= lock_enable;
      dev_busy <= ~rb_sync_r;
      case (state_r)
        S_IDLE: begin
          cmd_ready <= 1'b1;
          if (cmd_valid && cmd_ready) begin
            cmd_ready <= 1'b0;
            kind_r    <= cmd_kind;
            cnt_r     <= {`CNT_W{1'b0}};
            case (cmd_kind)
              `KIND_CMD, `KIND_ADDR, `KIND_WDATA: begin
                ce_n    <= 1'b0;
                cle     <= (cmd_kind == `KIND_CMD);
                ale     <= (cmd_kind == `KIND_ADDR);
                io_out  <= (cmd_kind == `KIND_WDATA) ? cmd_data : widen(cmd_data[7:0]);
                io_oe   <= 1'b1;
                state_r <= S_SETUP;
              end
              `KIND_ADDR5: begin
                ce_n       <= 1'b0;
                ale        <= 1'b1;
                addr_r     <= cmd_addr;
                byte_idx_r <= 3'h0;
                io_out     <= widen(cmd_addr[7:0]);
                io_oe      <= 1'b1;
                state_r    <= S_SETUP;
              end
              `KIND_RDATA: begin
                ce_n    <= 1'b0;
                io_oe   <= 1'b0;
                re_n    <= 1'b0;
                state_r <= S_RDLOW;
              end
              `KIND_WAIT: begin
                ce_n    <= 1'b1;
                state_r <= S_WAITB;
              end
              default: begin
                ce_n      <= 1'b1;
                cmd_done  <= 1'b1;
                cmd_ready <= 1'b0;
                state_r   <= S_IDLE;
              end
            endcase
          end
        end
        S_SETUP: begin
          if (cnt_r + 1'b1 >= SETUP_N) begin
            cnt_r   <= {`CNT_W{1'b0}};
            we_n    <= 1'b0;
            state_r <= S_STROBE;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        S_STROBE: begin
          if (cnt_r + 1'b1 >= WE_N) begin
            cnt_r   <= {`CNT_W{1'b0}};
            we_n    <= 1'b1;
            state_r <= S_HOLD;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        S_HOLD: begin
          if (cnt_r + 1'b1 >= HOLD_N) begin
            cnt_r <= {`CNT_W{1'b0}};
            if (kind_r == `KIND_ADDR5 && byte_idx_r != `ADDR_BYTES - 1) begin
              byte_idx_r <= byte_idx_r + 1'b1;
              addr_r     <= {8'h00, addr_r[`ADDR_BITS-1:8]};
              io_out     <= widen(addr_r[15:8]);
              state_r    <= S_SETUP;
            end else begin
              cle      <= 1'b0;
              ale      <= 1'b0;
              io_oe    <= 1'b0;
              cmd_done <= 1'b1;
              state_r  <= S_IDLE;
            end
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        S_RDLOW: begin
          if (cnt_r + 1'b1 >= RELOW_N) begin
            cnt_r   <= {`CNT_W{1'b0}};
            rd_data <= io_sync_r;
            re_n    <= 1'b1;
            state_r <= S_RDHIGH;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        S_RDHIGH: begin
          if (cnt_r + 1'b1 >= REHI_N) begin
            cnt_r    <= {`CNT_W{1'b0}};
            cmd_done <= 1'b1;
            state_r  <= S_IDLE;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        S_WAITB: begin
          // Let ready/busy fall before polling
          if (cnt_r + 1'b1 >= BSTRT_N) begin
            cnt_r   <= {`CNT_W{1'b0}};
            state_r <= S_WAITR;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        S_WAITR: begin
          if (rb_sync_r) begin
            cmd_done <= 1'b1;
            state_r  <= S_IDLE;
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

endmodule // nand_host_seq

// ### tb/nand_host_chk.sv
// Pin protocol assertions for the NAND host sequencer
`timescale 1ns/1ps
module nand_host_chk (
  input wire core_clk,
  input wire rst_n,
  input wire cmd_valid,
  input wire cmd_ready,
  input wire write_protect,
  input wire cle,
  input wire ale,
  input wire ce_n,
  input wire re_n,
  input wire we_n,
  input wire wp_n,
  input wire io_oe
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  a_latch_excl: assert property (!(cle && ale)) else $error("cle ale overlap");
  a_cle_we_high: assert property ($changed(cle) |-> we_n) else $error("cle moved");
  a_ale_we_high: assert property ($changed(ale) |-> we_n) else $error("ale moved");
  a_we_ce_low: assert property (!we_n |-> !ce_n) else $error("strobe unselected");
  a_re_bus_free: assert property (!re_n |-> !ce_n && !io_oe && we_n) else $error("read clash");
  a_we_data_held: assert property (!we_n |-> io_oe ##1 io_oe) else $error("data not held");
  a_wp_follows: assert property ($past(rst_n) |-> wp_n == !$past(write_protect)) else $error("wp lag");
  a_take_drops: assert property (cmd_valid && cmd_ready |=> !cmd_ready) else $error("ready kept");
  c_cmd: cover property (cle && !we_n);
  c_addr: cover property (ale && !we_n);
  c_read: cover property (!re_n);
endmodule // nand_host_chk

bind nand_host_seq nand_host_chk chk (
  .core_clk(core_clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
  .write_protect(write_protect), .cle(cle), .ale(ale), .ce_n(ce_n), .re_n(re_n),
  .we_n(we_n), .wp_n(wp_n), .io_oe(io_oe)
);

// ### tb/nand_dev_model.sv
// Behavioural flash device on the far side of the pins
`timescale 1ns/1ps
module nand_dev_model #(
  parameter BUSY_NS = 500
) (
  input  wire       ce_n,
  input  wire       cle,
  input  wire       ale,
  input  wire       we_n,
  input  wire       re_n,
  input  wire       wp_n,
  input  wire [7:0] io_out,
  input  wire       io_oe,
  output wire [7:0] io_in,
  output reg        rb_n_in
);
  reg [7:0]  cmd_r;
  reg [7:0]  dat_r = 8'h00;
  reg [39:0] addr_r;
  // address fields of the page array
  localparam [11:0] MAIN_BYTES  = 12'h800;
  localparam [11:0] SPARE_BYTES = 12'h040;
  wire [11:0] col_w   = addr_r[11:0];
  wire [5:0]  page_w  = addr_r[21:16];
  wire [10:0] blk_w   = addr_r[32:22];
  wire        addr_ok = (col_w < MAIN_BYTES + SPARE_BYTES) && (addr_r[15:12] == 4'h0) && (addr_r[39:33] == 7'h00);
  initial rb_n_in = 1'h1;
  always @(posedge we_n) begin
    if (!ce_n && cle) begin
      cmd_r = io_out;
      // busy on program or page load
      if ((io_out == 8'h10 && wp_n) || io_out == 8'h30) begin
        rb_n_in = 1'h0;
        #(BUSY_NS) rb_n_in = 1'h1;
      end
    end else if (!ce_n && ale) begin
      addr_r = {io_out, addr_r[39:8]};
    end else if (!ce_n) begin
      dat_r = io_out;
    end
  end
  // echo host byte while io_oe, data in a read, else stale inverse
  assign io_in = io_oe ? io_out : (!ce_n && !re_n) ? dat_r : ~dat_r;
endmodule // nand_dev_model

// ### tb/testbench.sv
// Self-checking bench for the NAND host sequencer
`timescale 1ns/1ps
`include "nand_host_defines.vh"
module testbench;
  reg         core_clk = 0;
  reg         rst_n = 0;
  reg         cmd_valid = 0;
  reg  [2:0]  cmd_kind = 0;
  reg  [7:0]  cmd_data = 0;
  reg  [39:0] cmd_addr = 0;
  reg         write_protect = 1;
  reg         lock_enable = 1;
  reg  [39:0] r, m_addr;
  reg  [31:0] u;
  reg  [7:0]  exp_q[$];
  integer     fails = 0, total_checks = 0, cyc = 0, i;
  wire        clk_en = 1'h1;
  wire        cmd_ready, cmd_done, dev_busy, cle, ale, ce_n, re_n, we_n, wp_n, lock, io_oe, rb_n_in;
  wire [7:0]  rd_data, io_out, io_in;
  nand_host_seq #(
    .IO_W(8)
  ) uut (
    .core_clk      (core_clk),
    .rst_n         (rst_n),
    .clk_en        (clk_en),
    .cmd_valid     (cmd_valid),
    .cmd_kind      (cmd_kind),
    .cmd_data      (cmd_data),
    .cmd_addr      (cmd_addr),
    .cmd_ready     (cmd_ready),
    .cmd_done      (cmd_done),
    .rd_data       (rd_data),
    .dev_busy      (dev_busy),
    .write_protect (write_protect),
    .lock_enable   (lock_enable),
    .cle           (cle),
    .ale           (ale),
    .ce_n          (ce_n),
    .re_n          (re_n),
    .we_n          (we_n),
    .wp_n          (wp_n),
    .lock          (lock),
    .io_out        (io_out),
    .io_oe         (io_oe),
    .io_in         (io_in),
    .rb_n_in       (rb_n_in)
  );
  nand_dev_model dev (
    .ce_n    (ce_n),
    .cle     (cle),
    .ale     (ale),
    .we_n    (we_n),
    .re_n    (re_n),
    .wp_n    (wp_n),
    .io_out  (io_out),
    .io_oe   (io_oe),
    .io_in   (io_in),
    .rb_n_in (rb_n_in)
  );
  always #12.5 core_clk = ~core_clk;
  task chk(input [39:0] got, input [39:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  task test_done;
    begin
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  task req(input [2:0] k, input [7:0] d, input [39:0] a);
    begin
      @(negedge core_clk);
      cmd_kind = k;
      cmd_data = d;
      cmd_addr = a;
      cmd_valid = 1;
      while (cmd_ready !== 1'h1) @(negedge core_clk);
      @(negedge core_clk);
      cmd_valid = 0;
      while (cmd_done !== 1'h1) @(negedge core_clk);
      chk({cmd_done, cmd_ready}, 2'h2);
    end
  endtask
  // Hang guard
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      fails = fails + 1;
      test_done;
    end
  end
  initial begin
    u = $urandom(26742);
    repeat (12) @(negedge core_clk);
    chk({ce_n, cle, ale, we_n, re_n, io_oe}, 6'h26);
    rst_n = 1;
    repeat (2) @(negedge core_clk);
    chk({wp_n, lock}, 2'h1);
    for (i = 0; i < 40; i = i + 1) begin
      u = $urandom;
      r = {u[7:0], $urandom};
      case (i % 5)
        0: begin
          u = $urandom % 32'h840;
          m_addr = {7'h00, r[10:0], r[21:16], 4'h0, u[11:0]};
          req(`KIND_ADDR5, 8'h00, m_addr);
          chk(dev.addr_r, m_addr);
          chk({dev.addr_ok, dev.blk_w, dev.page_w, dev.col_w}, {1'b1, r[10:0], r[21:16], u[11:0]});
        end
        1: begin
          req(`KIND_ADDR, r[7:0], 40'h0);
          m_addr = {r[7:0], m_addr[39:8]};
          chk(dev.addr_r, m_addr);
        end
        2: begin
          req(`KIND_CMD, {4'hC, r[3:0]}, 40'h0);
          chk(dev.cmd_r, {4'hC, r[3:0]});
        end
        3: begin
          req(`KIND_WDATA, r[7:0], 40'h0);
          exp_q.push_back(r[7:0]);
          chk(dev.dat_r, r[7:0]);
        end
        default: begin
          req(`KIND_RDATA, 8'h00, 40'h0);
          chk(rd_data, exp_q.pop_front());
        end
      endcase
    end
    // Program attempt while protected
    req(`KIND_CMD, 8'h10, 40'h0);
    repeat (6) @(negedge core_clk);
    chk(dev_busy, 1'h0);
    write_protect = 0;
    for (i = 0; i < 2; i = i + 1) begin
      req(`KIND_CMD, i ? 8'h30 : 8'h10, 40'h0);
      repeat (6) @(negedge core_clk);
      chk(dev_busy, 1'h1);
      req(`KIND_WAIT, 8'h00, 40'h0);
      chk({ce_n, dev_busy}, 2'h2);
    end
    req(`KIND_DESEL, 8'h00, 40'h0);
    chk(ce_n, 1'h1);
    test_done;
  end
endmodule // testbench
